// ==== common/pdc_pkg.sv ====
// constants, field layout and helpers of the packet command decoder
// Behaviour
// RULE1: control packet carries id 2, fields fixed
// RULE2: set force bit decodes exactly that frame
// RULE3: single phase bit picks one or all phases
// RULE4: phase mode change waits for block 0
// RULE5: phase field maps by data rate
// RULE6: forward errored or time block info words 2-4
// RULE7: restart bit restarts minute timer from zero
// RULE8: address end flag after last address word
// RULE9: run bit enables processing, else low power
// RULE10: host spaces run bit changes 2ms apart
// RULE11: host turns off with off, on, off
// RULE12: first gap at least larger shutdown or 2ms
// RULE13: second gap 2ms to warm-up minus 2ms
// RULE14: every frame packet carries id 3
// RULE15: mode active on nonzero counter or force
// RULE16: every frame mode requests end-of-frame status
// RULE17: decoder increments, host command decrements counters
// RULE18: counters saturate at 127 and 0
// RULE19: counters cleared on reset and turn off
// RULE20: decrement bit lowers every frame counter by one
// RULE21: force bit forces every frame mode
// RULE22: each set bit lowers matching temp counter
// RULE23: ignore zero bits, apply after whole packet
package pdc_pkg;
  localparam int PKT_BITS = 32;
  localparam logic [7:0] CTRL_ID = 8'h02;
  localparam logic [7:0] EVERY_ID = 8'h03;
  localparam int ID_LSB = 24;
  localparam int FORCE_LSB = 16;
  localparam int ONE_PHASE_BIT = 14;
  localparam int PHASE_LSB = 12;
  localparam int FWD_BIT = 6;
  localparam int RESTART_BIT = 4;
  localparam int END_EN_BIT = 1;
  localparam int RUN_BIT = 0;
  localparam int CNT_DEC_BIT = 23;
  localparam int FORCE_ALL_BIT = 22;
  localparam int TEMP_DEC_LSB = 0;
  localparam int N_TEMP = 16;
  localparam int N_CNT = 17;
  localparam int CNT_W = 7;
  localparam logic [6:0] CNT_MAX = 7'h7f;
  localparam logic [6:0] CNT_ZERO = 7'h00;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EVERY = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CNT_BASE = 8'h40;
  localparam logic [7:0] OFF_CNT_LAST = 8'h80;
  localparam int ST_RUN = 0;
  localparam int ST_EVERY = 1;
  localparam int ST_ADDR_END = 2;
  localparam int ST_ONE_PHASE = 3;
  localparam int ST_PHASE_LSB = 4;
  localparam int ST_FORCE = 6;
  localparam int ST_BIF = 7;
  localparam int ST_END_EN = 8;
  localparam int ST_FORCE_LSB = 16;
  localparam logic [1:0] RATE_1600 = 2'h0;
  localparam logic [1:0] RATE_3200 = 2'h1;
  localparam logic [1:0] RATE_6400 = 2'h2;
  localparam logic [2:0] BIW_FIRST = 3'h2;
  localparam logic [2:0] BIW_LAST = 3'h4;
  localparam logic [6:0] FORCE_FRAMES = 7'h08;
  localparam longint CLK_HZ = 64'd200000000;
  localparam longint MINUTE_S = 64'd60;
  localparam longint MINUTE_CYCLES = MINUTE_S * CLK_HZ;

  // phase lane 0..3 = a..d for a phase field at a data rate
  function automatic logic [1:0] phase_of(input logic [1:0] rate, input logic [1:0] code);
    logic [1:0] lane;
    lane = 2'h0;
    if (rate == RATE_3200)
      lane = {code[1], 1'b0};
    else if (rate == RATE_6400)
      lane = code;
    return lane;
  endfunction : phase_of
endpackage : pdc_pkg

// ==== common/pkt_if.sv ====
// one received four-byte packet between receiver and command logic
interface pkt_if;
  logic valid;
  logic [31:0] word;
  modport src (output valid, output word);
  modport dst (input valid, input word);
endinterface : pkt_if

// ==== core/pkt_receiver.sv ====
// serial packet receiver: synchronises link pins, shifts 32 bits msb first
module pkt_receiver (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  input wire logic link_sck, // host serial clock pin
  input wire logic link_mosi, // host serial data pin
  input wire logic link_sel_n, // host select pin, low active
  pkt_if.src pkt // completed packet
);
  logic [2:0] s1;
  logic [2:0] s2;
  logic sck_d;
  logic [4:0] nbits;
  logic [31:0] shift;
  logic valid;
  logic [31:0] word;
  wire sck_rise = s2[0] & ~sck_d;
  wire selected = ~s2[2];
  wire last_bit = sck_rise && selected && nbits == 5'(pdc_pkg::PKT_BITS - 1);
  wire [31:0] next_shift = {shift[30:0], s2[1]};

  always_ff @(posedge clk)
  begin
    s1 <= {link_sel_n, link_mosi, link_sck};
    s2 <= s1;
    sck_d <= s2[0];
  end

  always_ff @(posedge clk)
  begin
    if (srst || !selected)
    begin
      nbits <= 5'h00;
      shift <= 32'h00000000;
    end
    else if (sck_rise)
    begin
      nbits <= nbits + 5'h01;
      shift <= next_shift;
    end
  end

  // packet exists only once its last bit is in
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      valid <= 1'b0;
      word <= 32'h00000000;
    end
    else
    begin
      valid <= last_bit; // RULE23
      if (last_bit)
        word <= next_shift;
    end
  end

  assign pkt.valid = valid;
  assign pkt.word = word;
endmodule : pkt_receiver

// ==== core/sat_counter_bank.sv ====
// bank of saturating up/down counters with clear and one read port
module sat_counter_bank #(
  parameter int N = 17,
  parameter int W = 7
) (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  input wire logic clear, // clear all counters
  input wire logic [N-1:0] inc, // increment by one
  input wire logic [N-1:0] dec, // decrement by one
  input wire logic [4:0] sel, // read index
  output logic [W-1:0] sel_count, // selected counter
  output logic [N-1:0] nonzero // counter is nonzero
);
  logic [W-1:0] cnt [N];
  localparam logic [W-1:0] TOP = '1;

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (srst || clear)
        cnt[i] <= '0; // RULE19
      else if (inc[i] && !dec[i] && cnt[i] != TOP)
        cnt[i] <= cnt[i] + W'(1); // RULE17 RULE18
      else if (dec[i] && !inc[i] && cnt[i] != '0)
        cnt[i] <= cnt[i] - W'(1); // RULE18
    end
  end

  always_comb
  begin
    sel_count = '0;
    for (int i = 0; i < N; i++)
    begin
      nonzero[i] = cnt[i] != '0;
      if (sel == 5'(i))
        sel_count = cnt[i];
    end
  end
endmodule : sat_counter_bank

// ==== core/pager_decoder_ctrl_packets.sv ====
// control and every-frame packet command logic of the paging decoder
module pager_decoder_ctrl_packets #(
  parameter longint MINUTE_CYCLES = pdc_pkg::MINUTE_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  input wire logic link_sck, // host serial clock
  input wire logic link_mosi, // host serial data
  input wire logic link_sel_n, // host select, low active
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // register write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic [1:0] data_rate, // current data rate code
  input wire logic frame_start, // pulse, frame begins
  input wire logic [6:0] frame_num, // frame number at frame_start
  input wire logic block0, // pulse, block 0 of decoded frame
  input wire logic frame_end, // pulse, frame ends
  input wire logic addr_detect, // pulse, address matched
  input wire logic last_addr_word, // pulse, last address word decoded
  input wire logic biw_rx, // pulse, block info word received
  input wire logic [2:0] biw_index, // block info word number
  input wire logic biw_errored, // word uncorrectable
  input wire logic biw_time, // word carries time
  input wire logic short_vector, // pulse, temp address assigned
  input wire logic [3:0] short_vector_addr, // assigned temp address
  input wire logic long_vector, // pulse, alpha/hex/secure vector
  output logic run, // processing enabled
  output logic [7:0] frame_force_bits, // forced frames 0-7
  output logic force_decode_frame, // pulse, decode this frame
  output logic single_phase_select, // applied single phase mode
  output logic [1:0] phase_lane, // applied phase a..d
  output logic block_info_forward, // forwarding enabled
  output logic biw_send, // pulse, send word to host
  output logic minute_tick, // pulse, one minute elapsed
  output logic address_end_flag_enable, // end flag enabled
  output logic address_end_flag, // sticky end-of-addresses flag
  output logic force_every_frame, // forced every frame mode
  output logic every_frame_mode, // every frame mode active
  output logic eof_status_req // pulse, send end-of-frame status
);
  ////////////////////////////////////////////////////////////////////
  // packet sources
  pkt_if link_pkt ();

  pkt_receiver u_rx (
    .clk(clk),
    .srst(srst),
    .link_sck(link_sck),
    .link_mosi(link_mosi),
    .link_sel_n(link_sel_n),
    .pkt(link_pkt)
  );

  logic held;
  logic [31:0] held_word;
  wire bus_ctrl = wr && addr == pdc_pkg::OFF_CTRL;
  wire bus_every = wr && addr == pdc_pkg::OFF_EVERY;
  wire [31:0] bus_word = bus_ctrl ? {pdc_pkg::CTRL_ID, wdata[23:0]}
                                  : {pdc_pkg::EVERY_ID, wdata[23:0]};
  wire bus_pkt = bus_ctrl || bus_every;
  // link wins a collision, bus word waits one cycle
  wire pkt_valid = link_pkt.valid || held || bus_pkt;
  wire [31:0] pkt_word = link_pkt.valid ? link_pkt.word : (held ? held_word : bus_word);
  wire [7:0] pkt_id = pkt_word[31:pdc_pkg::ID_LSB];
  wire is_ctrl = pkt_valid && pkt_id == pdc_pkg::CTRL_ID; // RULE1
  wire is_every = pkt_valid && pkt_id == pdc_pkg::EVERY_ID; // RULE14

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      held <= 1'b0;
      held_word <= 32'h00000000;
    end
    else
    begin
      held <= link_pkt.valid ? (held || bus_pkt) : (held && bus_pkt);
      if (bus_pkt && !(link_pkt.valid && held))
        held_word <= bus_word;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control word fields
  logic one_phase_pend;
  logic [1:0] phase_pend;
  logic [1:0] phase_cur;
  wire ctrl_run = pkt_word[pdc_pkg::RUN_BIT];
  wire ctrl_restart = is_ctrl && pkt_word[pdc_pkg::RESTART_BIT];
  wire [7:0] ctrl_force = pkt_word[pdc_pkg::FORCE_LSB +: 8];
  wire next_run = is_ctrl ? ctrl_run : run;
  wire turn_off = run && !next_run;
  wire apply_phase = !run || block0;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      run <= 1'b0;
      frame_force_bits <= 8'h00;
      one_phase_pend <= 1'b0;
      phase_pend <= 2'h0;
      block_info_forward <= 1'b0;
      address_end_flag_enable <= 1'b0;
    end
    else if (is_ctrl)
    begin
      run <= ctrl_run; // RULE9
      frame_force_bits <= ctrl_force;
      one_phase_pend <= pkt_word[pdc_pkg::ONE_PHASE_BIT];
      phase_pend <= pkt_word[pdc_pkg::PHASE_LSB +: 2];
      block_info_forward <= pkt_word[pdc_pkg::FWD_BIT];
      address_end_flag_enable <= pkt_word[pdc_pkg::END_EN_BIT];
    end
  end

  // phase mode lands at block 0 while running, at once while off
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      single_phase_select <= 1'b0;
      phase_cur <= 2'h0;
    end
    else if (apply_phase)
    begin
      single_phase_select <= is_ctrl ? pkt_word[pdc_pkg::ONE_PHASE_BIT] : one_phase_pend; // RULE3 RULE4
      phase_cur <= is_ctrl ? pkt_word[pdc_pkg::PHASE_LSB +: 2] : phase_pend; // RULE4
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      phase_lane <= 2'h0;
    else
      phase_lane <= pdc_pkg::phase_of(data_rate, phase_cur); // RULE5
  end

  ////////////////////////////////////////////////////////////////////
  // frame, block info and address-end events
  wire force_hit = frame_num < pdc_pkg::FORCE_FRAMES && frame_force_bits[frame_num[2:0]];
  wire biw_in_range = biw_index >= pdc_pkg::BIW_FIRST && biw_index <= pdc_pkg::BIW_LAST;
  wire biw_go = run && biw_rx && block_info_forward && biw_in_range
                && (biw_errored || biw_time);
  logic addr_seen;
  wire ae_set = run && last_addr_word && address_end_flag_enable
                && (addr_seen || addr_detect);
  wire status_rd = rd && addr == pdc_pkg::OFF_STATUS;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      force_decode_frame <= 1'b0;
      biw_send <= 1'b0;
      eof_status_req <= 1'b0;
    end
    else
    begin
      force_decode_frame <= run && frame_start && force_hit; // RULE2
      biw_send <= biw_go; // RULE6
      eof_status_req <= run && frame_end && every_frame_mode; // RULE16
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst || frame_start)
      addr_seen <= 1'b0;
    else if (run && addr_detect)
      addr_seen <= 1'b1;
  end

  // set wins over the clear by a status read
  always_ff @(posedge clk)
  begin
    if (srst)
      address_end_flag <= 1'b0;
    else if (ae_set)
      address_end_flag <= 1'b1; // RULE8
    else if (status_rd)
      address_end_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // minute timer
  logic [35:0] minute_count;
  wire minute_wrap = minute_count == 36'(MINUTE_CYCLES - 64'd1);

  always_ff @(posedge clk)
  begin
    if (srst || ctrl_restart || minute_wrap || !run)
      minute_count <= 36'h000000000; // RULE7
    else
      minute_count <= minute_count + 36'h000000001;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      minute_tick <= 1'b0;
    else
      minute_tick <= run && minute_wrap && !ctrl_restart;
  end

  ////////////////////////////////////////////////////////////////////
  // every frame counters: 0..15 temp addresses, 16 every frame
  logic [pdc_pkg::N_CNT-1:0] inc;
  logic [pdc_pkg::N_CNT-1:0] dec;
  logic [pdc_pkg::N_CNT-1:0] nonzero;
  logic [6:0] sel_count;
  wire [7:0] cnt_off = addr - pdc_pkg::OFF_CNT_BASE;
  wire cnt_rd = addr >= pdc_pkg::OFF_CNT_BASE && addr <= pdc_pkg::OFF_CNT_LAST;

  always_comb
  begin
    inc = '0;
    dec = '0;
    if (run && short_vector)
      inc[short_vector_addr] = 1'b1; // RULE17
    inc[pdc_pkg::N_TEMP] = run && long_vector; // RULE17
    if (is_every)
    begin
      dec[pdc_pkg::N_TEMP-1:0] = pkt_word[pdc_pkg::TEMP_DEC_LSB +: pdc_pkg::N_TEMP]; // RULE22
      dec[pdc_pkg::N_TEMP] = pkt_word[pdc_pkg::CNT_DEC_BIT]; // RULE20
    end
  end

  sat_counter_bank #(
    .N(pdc_pkg::N_CNT),
    .W(pdc_pkg::CNT_W)
  ) u_cnt (
    .clk(clk),
    .srst(srst),
    .clear(turn_off), // RULE19
    .inc(inc),
    .dec(dec),
    .sel(cnt_off[6:2]),
    .sel_count(sel_count),
    .nonzero(nonzero)
  );

  always_ff @(posedge clk)
  begin
    if (srst)
      force_every_frame <= 1'b0;
    else if (is_every)
      force_every_frame <= pkt_word[pdc_pkg::FORCE_ALL_BIT]; // RULE21
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      every_frame_mode <= 1'b0;
    else
      every_frame_mode <= (|nonzero) || force_every_frame; // RULE15
  end

  ////////////////////////////////////////////////////////////////////
  // register read port
  logic [31:0] status_word;

  always_comb
  begin
    status_word = 32'h00000000;
    status_word[pdc_pkg::ST_RUN] = run;
    status_word[pdc_pkg::ST_EVERY] = every_frame_mode;
    status_word[pdc_pkg::ST_ADDR_END] = address_end_flag;
    status_word[pdc_pkg::ST_ONE_PHASE] = single_phase_select;
    status_word[pdc_pkg::ST_PHASE_LSB +: 2] = phase_lane;
    status_word[pdc_pkg::ST_FORCE] = force_every_frame;
    status_word[pdc_pkg::ST_BIF] = block_info_forward;
    status_word[pdc_pkg::ST_END_EN] = address_end_flag_enable;
    status_word[pdc_pkg::ST_FORCE_LSB +: 8] = frame_force_bits;
  end

  wire cnt_word_ok = cnt_rd && cnt_off[1:0] == 2'h0;
  wire [31:0] next_rdata = status_rd ? status_word
                         : (cnt_word_ok ? {25'h0, sel_count} : 32'h00000000);

  always_ff @(posedge clk)
  begin
    if (srst)
      rdata <= 32'h00000000;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_run_apply;
    @(posedge clk) disable iff (srst)
    is_ctrl |=> run == $past(pkt_word[pdc_pkg::RUN_BIT]);
  endproperty
  a_run_apply: assert property (p_run_apply) else $error("run bit not applied"); // RULE9

  property p_foreign_id;
    @(posedge clk) disable iff (srst)
    pkt_valid && pkt_id != pdc_pkg::CTRL_ID && pkt_id != pdc_pkg::EVERY_ID
      |=> $stable(run) && $stable(force_every_frame);
  endproperty
  a_foreign_id: assert property (p_foreign_id) else $error("foreign packet acted"); // RULE1

  property p_force_frame;
    @(posedge clk) disable iff (srst)
    run && frame_start && frame_num < pdc_pkg::FORCE_FRAMES
      && frame_force_bits[frame_num[2:0]] |=> force_decode_frame;
  endproperty
  a_force_frame: assert property (p_force_frame) else $error("forced frame missed"); // RULE2

  property p_phase_hold;
    @(posedge clk) disable iff (srst)
    $changed(single_phase_select) && $past(run) |-> $past(block0);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase mode moved early"); // RULE4

  property p_phase_1600;
    @(posedge clk) disable iff (srst)
    data_rate == pdc_pkg::RATE_1600 |=> phase_lane == 2'h0;
  endproperty
  a_phase_1600: assert property (p_phase_1600) else $error("phase not a at low rate"); // RULE5

  property p_biw;
    @(posedge clk) disable iff (srst)
    biw_send |-> $past(block_info_forward) && $past(biw_index) >= pdc_pkg::BIW_FIRST
      && $past(biw_index) <= pdc_pkg::BIW_LAST;
  endproperty
  a_biw: assert property (p_biw) else $error("block info word sent wrongly"); // RULE6

  property p_minute;
    @(posedge clk) disable iff (srst)
    ctrl_restart ##1 run [*3] |-> minute_count == 36'h000000002;
  endproperty
  a_minute: assert property (p_minute) else $error("minute timer not restarted"); // RULE7

  property p_addr_end;
    @(posedge clk) disable iff (srst)
    $rose(address_end_flag) |-> $past(address_end_flag_enable) && $past(last_addr_word);
  endproperty
  a_addr_end: assert property (p_addr_end) else $error("address end raised wrongly"); // RULE8

  property p_every_force;
    @(posedge clk) disable iff (srst)
    is_every && pkt_word[pdc_pkg::FORCE_ALL_BIT] |=> ##1 every_frame_mode;
  endproperty
  a_every_force: assert property (p_every_force) else $error("force not honoured"); // RULE21

  property p_eof;
    @(posedge clk) disable iff (srst)
    run && frame_end && every_frame_mode |=> eof_status_req;
  endproperty
  a_eof: assert property (p_eof) else $error("end-of-frame status missing"); // RULE16

  property p_off_clear;
    @(posedge clk) disable iff (srst)
    turn_off |=> nonzero == '0 ##1 (every_frame_mode == force_every_frame);
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("counters kept at turn off"); // RULE19

  property p_mode_source;
    @(posedge clk) disable iff (srst)
    every_frame_mode |-> $past(|nonzero) || $past(force_every_frame);
  endproperty
  a_mode_source: assert property (p_mode_source) else $error("mode without cause"); // RULE15

  c_turn_off: cover property (@(posedge clk) disable iff (srst)
    $fell(run) ##[1:1000] $rose(run) ##[1:1000] $fell(run));
  c_every_mode: cover property (@(posedge clk) disable iff (srst) $rose(every_frame_mode));
  c_addr_end: cover property (@(posedge clk) disable iff (srst) $rose(address_end_flag));
endmodule : pager_decoder_ctrl_packets

// ==== verif/host_link_model.sv ====
// host side of the serial packet link: sends 32-bit packets msb first
module host_link_model #(
  parameter int HALF_NS = 24,
  parameter int GAP_NS = 2000
) (
  output logic sck, // serial clock, still outside frames
  output logic mosi, // serial data
  output logic sel_n // select, low active
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sck = 1'b0;
    mosi = 1'b0;
    sel_n = 1'b1;
  end
  // id byte leaves first, data set up while the clock is low
  task automatic send(input logic [31:0] w);
    sel_n = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      mosi = w[i];
      #HALF_NS sck = 1'b1;
      #HALF_NS sck = 1'b0;
    end
    #HALF_NS sel_n = 1'b1;
    mosi = ~mosi;
  endtask : send
  // off, on, off; gaps scaled down, middle gap kept short of the warm-up time
  task automatic turn_off(input logic [31:0] off_w, input logic [31:0] on_w);
    send(off_w);
    #GAP_NS send(on_w);
    #GAP_NS send(off_w);
  endtask : turn_off
endmodule : host_link_model

// ==== verif/tb_pager_decoder_ctrl_packets.sv ====
// self-checking bench of the control and every-frame packet logic
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_pager_decoder_ctrl_packets;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_prev = 1'b0;
  logic [31:0] rdata;
  logic [1:0] data_rate = 2'h0;
  logic [7:0] ev = 8'h00;
  logic [6:0] frame_num = 7'h00;
  logic [2:0] biw_index = 3'h0;
  logic biw_errored = 1'b0;
  logic biw_time = 1'b0;
  logic [3:0] sv_addr = 4'h0;
  logic sck, mosi, sel_n;
  logic run, fdec, one_phase, bif, bsend, tick, end_en, aef, force_o, efm, eof;
  logic [7:0] force_bits;
  logic [1:0] lane;
  logic [1:0] pv;
  logic [7:0] fbv;
  logic [63:0] ent;
  logic [63:0] exp_q[$];
  int fail_count = 0;
  int checks = 0;
  int seed = 64;
  int n;
  int k;
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  host_link_model u_host_link_model (.sck(sck), .mosi(mosi), .sel_n(sel_n));
  pager_decoder_ctrl_packets #(.MINUTE_CYCLES(200)) u_pager_decoder_ctrl_packets (
    .clk(clk), .srst(srst), .link_sck(sck), .link_mosi(mosi), .link_sel_n(sel_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .data_rate(data_rate),
    .frame_start(ev[0]), .frame_num(frame_num), .block0(ev[1]), .frame_end(ev[2]),
    .addr_detect(ev[3]), .last_addr_word(ev[4]), .biw_rx(ev[5]), .biw_index(biw_index),
    .biw_errored(biw_errored), .biw_time(biw_time), .short_vector(ev[6]),
    .short_vector_addr(sv_addr), .long_vector(ev[7]), .run(run),
    .frame_force_bits(force_bits), .force_decode_frame(fdec),
    .single_phase_select(one_phase), .phase_lane(lane),
    .block_info_forward(bif), .biw_send(bsend), .minute_tick(tick),
    .address_end_flag_enable(end_en), .address_end_flag(aef), .force_every_frame(force_o),
    .every_frame_mode(efm), .eof_status_req(eof));
  ////////////////////////////////////////////////////////////////////////////
  // f = {forward, restart, end enable, run}
  function automatic logic [31:0] cw(input logic [7:0] fb, input logic [2:0] sp,
    input logic [3:0] f);
    return {8'h02, fb, 1'b0, sp, 4'h0, 1'b0, f[3], 1'b0, f[2], 2'b00, f[1], f[0]};
  endfunction : cw
  function automatic logic [1:0] lane_of(input int r, input logic [1:0] p);
    return (r == 0) ? 2'h0 : (r == 1) ? {p[1], 1'b0} : p;
  endfunction : lane_of
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= {8'h00, d[23:0]};
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr32
  task automatic rd32(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd32
  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev <= 8'h00;
    #1;
  endtask : pulse
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  // read answers, oldest note first
  always @(posedge clk)
  begin
    rd_prev <= rd;
    if (rd_prev)
    begin
      ent = exp_q.pop_front();
      `CHK("rdata", ent[31:0], rdata & ent[63:32])
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    rd32(8'h08, 32'h0, 32'hffffffff);
    rd32(8'h80, 32'h0, 32'h7f);
    wr32(8'h0c, 32'hffffff);
    rd32(8'h0c, 32'h0, 32'hffffffff);
    $display("done: reset");
    data_rate <= 2'h2;
    wr32(8'h00, cw(8'h00, 3'b111, 4'h0));
    repeat (3) @(posedge clk);
    #1;
    `CHK("lane", 2'h3, lane)
    `CHK("one phase", 1'b1, one_phase)
    pv = 2'h3;
    for (int r = 0; r < 3; r++)
    begin
      data_rate <= r[1:0];
      for (int p = 0; p < 4; p++)
      begin
        wr32(8'h00, cw(8'h00, {1'b1, p[1:0]}, 4'h1));
        repeat (3) @(posedge clk);
        #1;
        `CHK("lane held", lane_of(r, pv), lane)
        pulse(1);
        @(posedge clk);
        #1;
        `CHK("lane", lane_of(r, p[1:0]), lane)
        pv = p[1:0];
      end
    end
    wr32(8'h00, cw(8'h00, 3'b000, 4'h1));
    repeat (3) @(posedge clk);
    #1;
    `CHK("one phase held", 1'b1, one_phase)
    pulse(1);
    @(posedge clk);
    #1;
    `CHK("one phase", 1'b0, one_phase)
    $display("done: phase");
    fbv = $random(seed) | 8'h01;
    wr32(8'h00, cw(fbv, 3'b000, 4'h1));
    for (int f = 0; f < 10; f++)
    begin
      frame_num <= f[6:0];
      pulse(0);
      `CHK("force", (f < 8) ? fbv[f % 8] : 1'b0, fdec)
    end
    `CHK("force bits", fbv, force_bits)
    $display("done: frames");
    for (int s = 0; s < 2; s++)
    begin
      wr32(8'h00, cw(8'h00, 3'b000, {s[0], 3'b001}));
      for (int i = 0; i < 24; i++)
      begin
        biw_index <= 3'(i / 4 + 1);
        biw_errored <= i[0];
        biw_time <= i[1];
        pulse(5);
        `CHK("biw", s[0] && ((i / 4 + 1) inside {[2:4]}) && (i[0] || i[1]), bsend)
      end
      `CHK("forward", s[0], bif)
      wr32(8'h00, cw(8'h00, 3'b000, {2'b00, s[0], 1'b1}));
      pulse(0);
      pulse(4);
      rd32(8'h08, 32'h0, 32'h4);
      pulse(3);
      pulse(4);
      rd32(8'h08, {29'h0, s[0], 2'b00}, 32'h4);
      rd32(8'h08, 32'h0, 32'h4);
      `CHK("end enable", s[0], end_en)
    end
    $display("done: block info, address end");
    repeat (150) @(posedge clk);
    wr32(8'h00, cw(8'h00, 3'b000, 4'h5));
    n = 0;
    while (tick !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 300)
    begin
      fail_count++;
      report_and_stop();
    end
    `CHK("minute", 1'b1, n >= 195 && n <= 205)
    $display("done: minute");
    sv_addr <= 4'h3;
    repeat (130) pulse(6);
    rd32(8'h4c, 32'h7f, 32'h7f);
    rd32(8'h08, 32'h2, 32'h2);
    pulse(2);
    `CHK("eof", 1'b1, eof)
    u_host_link_model.send({8'h03, 8'h00, 16'h0008});
    repeat (20) @(posedge clk);
    rd32(8'h4c, 32'h7e, 32'h7f);
    k = ($random(seed) & 3) + 1;
    repeat (k) pulse(7);
    wr32(8'h04, 32'h0);
    rd32(8'h80, k, 32'h7f);
    for (int i = 0; i <= k; i++)
      wr32(8'h04, 32'h800000);
    rd32(8'h80, 32'h0, 32'h7f);
    u_host_link_model.turn_off(cw(8'h00, 3'b000, 4'h0), cw(8'h00, 3'b000, 4'h1));
    repeat (20) @(posedge clk);
    `CHK("run", 1'b0, run)
    rd32(8'h4c, 32'h0, 32'h7f);
    wr32(8'h00, cw(8'h00, 3'b000, 4'h1));
    wr32(8'h04, 32'h400000);
    repeat (2) @(posedge clk);
    #1;
    `CHK("every", 1'b1, efm)
    `CHK("force every", 1'b1, force_o)
    pulse(2);
    `CHK("eof", 1'b1, eof)
    wr32(8'h04, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    `CHK("every", 1'b0, efm)
    `CHK("force every", 1'b0, force_o)
    pulse(2);
    `CHK("eof", 1'b0, eof)
    u_host_link_model.send({8'h06, 24'h000000});
    repeat (20) @(posedge clk);
    `CHK("run", 1'b1, run)
    $display("done: counters");
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : tb_pager_decoder_ctrl_packets
